// ---- nvs_host.sv ----
// Purpose: Host controller driving a battery-backed byte-wide SRAM by its pins
// Assumes: Device is asynchronous; power_good_in comes from a supply monitor pin
// Notes:   One access at a time; requests are held off while locked out
//
// Contract
// [R01] Device writes while write strobe and chip select are both low.
// [R02] Write starts at the later falling edge of strobe or select.
// [R03] Write ends and commits at the earlier rising strobe or select edge.
// [R04] Host holds the address stable across the whole write.
// [R05] Host raises select or strobe and holds address before the next cycle.
// [R06] Host holds write data valid before and after the terminating edge.
// [R07] Host meets write cycle time and strobe and select low widths.
// [R08] Host keeps output enable high during writes.
// [R09] Device floats driven outputs shortly after the write strobe falls.
// [R10] Select and strobe falling together keep outputs floating all cycle.
// [R11] On power fail the device blocks writes and ignores inputs.
// [R12] Power failure mid-write may corrupt only the byte being written.
// [R13] Fast supply fall may delay deselect by up to the stated time.
// [R14] After recovery the device ignores inputs for the recovery interval.
// [R15] Host keeps chip select high while the supply rises.
// [R16] Select and output enable low with strobe high reads the byte.
// [R17] Power-good low or recovery running means the device is deselected.
`timescale 1ns/10ps
`default_nettype none

module nvs_host
  import nvs_pkg::*;
#(
  parameter int RECOVERY_COUNT = RECOVERY_CYCLES
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // Supply monitor
  input  wire logic              power_good_in,
  // User request
  input  wire nvs_req_type       req_in,
  input  wire logic              req_valid_in,
  output var  logic              req_ready_out,
  output var  logic [DATA_W-1:0] rd_data_out,
  output var  logic              rd_valid_out,
  // Device pins
  output var  logic              chip_select_n_out,
  output var  logic              write_strobe_n_out,
  output var  logic              output_enable_n_out,
  output var  logic [ADDR_W-1:0] byte_address_out,
  output var  logic [DATA_W-1:0] data_bus_out,
  output var  logic              data_bus_oe_out,
  input  wire logic [DATA_W-1:0] data_bus_in
);

  // ****************************************************************
  // Power-good synchroniser
  // ****************************************************************
  logic [2:0] pg_sync;
  logic       pg_stable;
  logic       next_pg_stable;

  always_comb begin
    next_pg_stable = pg_stable;
    if (pg_sync[1] == pg_sync[2]) begin
      next_pg_stable = pg_sync[2];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pg_sync   <= 3'b000;
      pg_stable <= 1'b0;
    end else begin
      pg_sync   <= {pg_sync[1:0], power_good_in};
      pg_stable <= next_pg_stable;
    end
  end

  // ****************************************************************
  // Data bus input sampling for reads
  // ****************************************************************
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [DATA_W-1:0] dq_s3;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
    end else begin
      dq_s1 <= data_bus_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  nvs_state_type     state;
  nvs_state_type     next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  nvs_pins_type      pins;
  nvs_pins_type      next_pins;
  logic              ready;
  logic              next_ready;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;
  logic              rd_valid;
  logic              next_rd_valid;
  logic              timer_done;

  assign timer_done = (timer == '0);

  always_comb begin
    next_state    = state;
    next_timer    = timer_done ? timer : timer - 1'b1;
    next_pins     = pins;
    next_ready    = 1'b0;
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    unique case (state)
      ST_LOCK: begin
        next_pins = PINS_IDLE;                                  // R15
        if (!pg_stable) begin
          next_timer = TIMER_W'(RECOVERY_COUNT);                // R14
        end else if (timer_done) begin
          next_state = ST_IDLE;                                 // R17
          next_ready = 1'b1;
        end
      end
      ST_IDLE: begin
        next_ready = 1'b1;
        if (req_valid_in && ready) begin
          next_ready              = 1'b0;
          next_pins.byte_address  = req_in.byte_address;        // R04
          next_pins.output_enable_n = 1'b1;                     // R08
          if (req_in.write) begin
            next_pins.data_bus_out = req_in.data;
            next_pins.data_bus_oe  = 1'b1;
            next_state             = ST_WSETUP;
          end else begin
            next_pins.chip_select_n   = 1'b0;                   // R16
            next_pins.output_enable_n = 1'b0;
            next_timer                = TIMER_W'(READ_CYCLES + 2);
            next_state                = ST_READ;
          end
        end
      end
      ST_WSETUP: begin
        // Select and strobe fall together so outputs never turn on
        next_pins.chip_select_n  = 1'b0;                        // R10
        next_pins.write_strobe_n = 1'b0;                        // R01 R02
        next_timer               = TIMER_W'(STROBE_CYCLES - 1);
        next_state               = ST_WSTRB;
      end
      ST_WSTRB: begin
        if (timer_done) begin
          next_pins.write_strobe_n = 1'b1;                      // R03 R07
          next_pins.chip_select_n  = 1'b1;
          next_timer               = TIMER_W'(HOLD_CYCLES - 1);
          next_state               = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        if (timer_done) begin
          next_pins.data_bus_oe = 1'b0;                         // R06
          next_timer            = TIMER_W'(CYCLE_CYCLES - 1);
          next_state            = ST_GAP;
        end
      end
      ST_READ: begin
        if (timer_done) begin
          next_rd_data              = dq_s3;
          next_rd_valid             = 1'b1;
          next_pins.chip_select_n   = 1'b1;
          next_pins.output_enable_n = 1'b1;
          next_timer                = TIMER_W'(FLOAT_CYCLES - 1);
          next_state                = ST_GAP;
        end
      end
      ST_GAP: begin
        // Address stays put after the rising edge before the next cycle
        if (timer_done) begin                                   // R05
          next_state = ST_IDLE;
          next_ready = 1'b1;
        end
      end
      default: begin
        next_state = ST_LOCK;
        next_pins  = PINS_IDLE;
      end
    endcase
    // Supply loss abandons any access and releases the bus
    if (!pg_stable) begin                                       // R11 R12 R13
      next_state = ST_LOCK;
      next_pins  = PINS_IDLE;
      next_ready = 1'b0;
      next_timer = TIMER_W'(RECOVERY_COUNT);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state    <= ST_LOCK;
      timer    <= '0;
      pins     <= PINS_IDLE;
      ready    <= 1'b0;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      state    <= next_state;
      timer    <= next_timer;
      pins     <= next_pins;
      ready    <= next_ready;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_ready_out       = ready;
  assign rd_data_out         = rd_data;
  assign rd_valid_out        = rd_valid;
  assign chip_select_n_out   = pins.chip_select_n;
  assign write_strobe_n_out  = pins.write_strobe_n;
  assign output_enable_n_out = pins.output_enable_n;
  assign byte_address_out    = pins.byte_address;
  assign data_bus_out        = pins.data_bus_out;
  assign data_bus_oe_out     = pins.data_bus_oe;

endmodule : nvs_host

`default_nettype wire

// ---- nvs_host_asserts.sv ----
// Purpose: Pin protocol checks for nvs_host
// Assumes: One clock, reset active high
// Notes:   Bound to every nvs_host instance
`timescale 1ns/10ps
`default_nettype none
module nvs_host_asserts
  import nvs_pkg::*;
#(
  parameter int RECOVERY_COUNT = 20
) (
  // Watched ports
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire logic              power_good_in,
  input wire logic              chip_select_n_out,
  input wire logic              write_strobe_n_out,
  input wire logic              output_enable_n_out,
  input wire logic [ADDR_W-1:0] byte_address_out,
  input wire logic              data_bus_oe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  int pg_cnt;
  int next_pg_cnt;
  // ********
  // Cycles of good power
  // ********
  always_comb begin
    next_pg_cnt = 0;
    if (power_good_in)
      next_pg_cnt = (pg_cnt > RECOVERY_COUNT) ? pg_cnt : pg_cnt + 1;
  end
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in)
      pg_cnt <= 0;
    else
      pg_cnt <= next_pg_cnt;
  end
  sequence s_wr_hold;
    (!write_strobe_n_out && data_bus_oe_out)[*2] ##1 (write_strobe_n_out && data_bus_oe_out);
  endsequence
  chk_addr_stable:
    assert property ((!chip_select_n_out && !write_strobe_n_out)
      |=> (chip_select_n_out || $stable(byte_address_out))) else $error("address moved");
  chk_addr_hold:
    assert property (disable iff (rst_in || !power_good_in)
      $rose(write_strobe_n_out) |-> $stable(byte_address_out)) else $error("no address hold");
  chk_strobe_width:
    assert property (disable iff (rst_in || !power_good_in)
      $fell(write_strobe_n_out) |-> s_wr_hold) else $error("bad strobe width");
  chk_write_data:
    assert property (!write_strobe_n_out |-> data_bus_oe_out) else $error("data not driven");
  chk_oe_idle:
    assert property ((!write_strobe_n_out || data_bus_oe_out) |-> output_enable_n_out)
      else $error("output enable low");
  chk_lost_power:
    assert property ((!power_good_in)[*6] |-> chip_select_n_out && write_strobe_n_out
      && !data_bus_oe_out) else $error("pins live without power");
  chk_recovery_hold:
    assert property ((power_good_in && pg_cnt < RECOVERY_COUNT) |-> chip_select_n_out)
      else $error("select during recovery");
endmodule : nvs_host_asserts
bind nvs_host nvs_host_asserts #(.RECOVERY_COUNT(RECOVERY_COUNT)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .power_good_in(power_good_in),
  .chip_select_n_out(chip_select_n_out), .write_strobe_n_out(write_strobe_n_out),
  .output_enable_n_out(output_enable_n_out), .byte_address_out(byte_address_out),
  .data_bus_oe_out(data_bus_oe_out));
`default_nettype wire

// ---- nvs_pkg.sv ----
// Purpose: Shared constants and types for the battery-backed SRAM host controller
// Assumes: 20 MHz system clock, byte-wide asynchronous SRAM on the far side
// Notes:   Times are kept in their printed units; cycle counts derive from them
package nvs_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS        = 50;
  localparam int WRITE_CYCLE_NS       = 70;
  localparam int WRITE_PULSE_NS       = 50;
  localparam int SELECT_PULSE_NS      = 55;
  localparam int ADDR_SETUP_END_NS    = 60;
  localparam int DATA_SETUP_NS        = 30;
  localparam int DATA_HOLD_NS         = 5;
  localparam int READ_ACCESS_NS       = 70;
  localparam int STROBE_TO_FLOAT_NS   = 25;
  localparam int RECOVERY_MAX_MS      = 200;

  function automatic int ns_to_cycles_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles_min

  // Strobe low width covers pulse, select width and address-to-end setup
  localparam int STROBE_NS_MAX = (SELECT_PULSE_NS > ADDR_SETUP_END_NS) ?
                                 SELECT_PULSE_NS : ADDR_SETUP_END_NS;
  localparam int STROBE_CYCLES  = ns_to_cycles_min(STROBE_NS_MAX);
  localparam int HOLD_CYCLES    = ns_to_cycles_min(DATA_HOLD_NS);
  localparam int READ_CYCLES    = ns_to_cycles_min(READ_ACCESS_NS);
  localparam int FLOAT_CYCLES   = ns_to_cycles_min(STROBE_TO_FLOAT_NS);
  localparam int CYCLE_CYCLES   = ns_to_cycles_min(WRITE_CYCLE_NS);
  // Host waits the full maximum recovery before touching the device
  localparam int RECOVERY_CYCLES = RECOVERY_MAX_MS * 1000 * (1000 / CLK_PERIOD_NS);
  localparam int TIMER_W        = 24;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] byte_address;
    logic [DATA_W-1:0] data;
  } nvs_req_type;

  typedef struct packed {
    logic              chip_select_n;
    logic              write_strobe_n;
    logic              output_enable_n;
    logic [ADDR_W-1:0] byte_address;
    logic [DATA_W-1:0] data_bus_out;
    logic              data_bus_oe;
  } nvs_pins_type;

  localparam nvs_pins_type PINS_IDLE = '{
    chip_select_n:   1'b1,
    write_strobe_n:  1'b1,
    output_enable_n: 1'b1,
    byte_address:    15'h0000,
    data_bus_out:    8'h00,
    data_bus_oe:     1'b0
  };

  typedef enum logic [6:0] {
    ST_LOCK   = 7'b000_0001,
    ST_IDLE   = 7'b000_0010,
    ST_WSETUP = 7'b000_0100,
    ST_WSTRB  = 7'b000_1000,
    ST_WHOLD  = 7'b001_0000,
    ST_READ   = 7'b010_0000,
    ST_GAP    = 7'b100_0000
  } nvs_state_type;

endpackage : nvs_pkg

// ---- nvs_sram_model.sv ----
// Purpose: Behavioural battery-backed byte-wide SRAM
// Assumes: Data lines are resolved here from both drivers
// Notes:   Released lines show the inverse of the addressed byte
`timescale 1ns/10ps
`default_nettype none
module nvs_sram_model
  import nvs_pkg::*;
#(
  parameter int REC_NS = 800
) (
  // Host pins
  input  wire logic              power_good_in,
  input  wire logic              chip_select_n_in,
  input  wire logic              write_strobe_n_in,
  input  wire logic              output_enable_n_in,
  input  wire logic [ADDR_W-1:0] byte_address_in,
  input  wire logic [DATA_W-1:0] host_data_in,
  input  wire logic              host_oe_in,
  // Resolved data lines
  output wire logic [DATA_W-1:0] data_bus_out
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic              alive = 1'b0;
  wire               ok = alive && power_good_in;
  wire               end_edge = chip_select_n_in | write_strobe_n_in;
  wire               drive = ok && !chip_select_n_in && !output_enable_n_in
                             && write_strobe_n_in;
  always @(negedge power_good_in) alive = 1'b0;
  always @(posedge power_good_in) begin
    #REC_NS;
    alive = power_good_in;
  end
  // Byte commits at the first rising select or strobe
  always @(posedge end_edge) begin
    if (ok)
      mem[byte_address_in] <= data_bus_out;
  end
  assign data_bus_out = host_oe_in ? host_data_in :
                        drive ? mem[byte_address_in] : ~mem[byte_address_in];
endmodule : nvs_sram_model
`default_nettype wire

// ---- test_nv_sram_write_and_power_fail_protect.sv ----
// Purpose: Self-checking bench for the SRAM host controller
// Assumes: Recovery shortened to REC cycles
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/10ps
`default_nettype none
module test_nv_sram_write_and_power_fail_protect
  import nvs_pkg::*;
;
  localparam int REC = 20;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              pg = 1'b0;
  nvs_req_type       req = '0;
  logic              req_valid = 1'b0;
  logic              ready, rd_valid, cs_n, we_n, oe_n, d_oe;
  logic [DATA_W-1:0] rd_data, d_out;
  logic [ADDR_W-1:0] addr;
  wire  [DATA_W-1:0] d_in;
  int                n_mismatch = 0;
  int                total_checks = 0;
  always #25 sys_clk = ~sys_clk;
  nvs_host #(.RECOVERY_COUNT(REC)) u_dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .power_good_in(pg), .req_in(req),
    .req_valid_in(req_valid), .req_ready_out(ready), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .chip_select_n_out(cs_n), .write_strobe_n_out(we_n),
    .output_enable_n_out(oe_n), .byte_address_out(addr), .data_bus_out(d_out),
    .data_bus_oe_out(d_oe), .data_bus_in(d_in));
  nvs_sram_model u_dev (
    .power_good_in(pg), .chip_select_n_in(cs_n), .write_strobe_n_in(we_n),
    .output_enable_n_in(oe_n), .byte_address_in(addr), .host_data_in(d_out),
    .host_oe_in(d_oe), .data_bus_out(d_in));
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic cmp_d(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_d
  task automatic cmp_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_b
  task automatic wait_hi(ref logic sig);
    int i = 0;
    do @(negedge sys_clk); while (++i < 400 && sig !== 1'b1);
    if (sig !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      close_out();
    end
  endtask : wait_hi
  task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wait_hi(ready);
    @(posedge sys_clk);
    req <= '{write: w, byte_address: a, data: d};
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask : send
  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    send(1'b0, a, 8'h00);
    wait_hi(rd_valid);
    cmp_d(rd_data, exp);
  endtask : read_chk
  task automatic lock_wait;
    int n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    cmp_b(n > REC && n < 400, 1'b1);
    if (n >= 400)
      close_out();
  endtask : lock_wait
  task automatic t_boot;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pg <= 1'b1;
    lock_wait();
    $display("test boot done");
  endtask : t_boot
  task automatic t_write_read;
    logic [ADDR_W-1:0] wa [4] = '{15'h0000, 15'h7FFF, 15'h0001, 15'h0000};
    logic [DATA_W-1:0] wd [4] = '{8'hA5, 8'h5A, 8'h00, 8'h3C};
    for (int i = 0; i < 4; i++)
      send(1'b1, wa[i], wd[i]);
    read_chk(15'h7FFF, 8'h5A);
    read_chk(15'h0001, 8'h00);
    read_chk(15'h0000, 8'h3C);
    $display("test write_read done");
  endtask : t_write_read
  task automatic t_power;
    send(1'b1, 15'h0002, 8'hC3);
    pg <= 1'b0;
    repeat (8) @(negedge sys_clk);
    cmp_b(cs_n & we_n & ~d_oe, 1'b1);
    cmp_b(ready, 1'b0);
    @(posedge sys_clk);
    pg <= 1'b1;
    lock_wait();
    read_chk(15'h7FFF, 8'h5A);
    read_chk(15'h0001, 8'h00);
    $display("test power_fail done");
  endtask : t_power
  initial begin
    t_boot();
    t_write_read();
    t_power();
    close_out();
  end
endmodule : test_nv_sram_write_and_power_fail_protect
`default_nettype wire
